// ### core/dcxf_pkg.sv
package dcxf_pkg;

    // ****************************************************************
    // register map (byte addresses, one word each)
    // ****************************************************************
    localparam logic [7:0]  OFS_CRC_CONTROL   = 8'h00;
    localparam logic [7:0]  OFS_CRC_SEED      = 8'h04;
    localparam logic [7:0]  OFS_CRC_XOR_TAP   = 8'h08;
    localparam logic [7:0]  OFS_CRC_DATA_IN   = 8'h0c;
    localparam logic [7:0]  OFS_CHAN_CONTROL  = 8'h10;
    localparam logic [7:0]  OFS_SOURCE_SIZE   = 8'h14;
    localparam logic [7:0]  OFS_DEST_SIZE     = 8'h18;
    localparam logic [7:0]  OFS_CELL_SIZE     = 8'h1c;
    localparam logic [7:0]  OFS_ABORT_IRQ     = 8'h20;
    localparam logic [7:0]  OFS_EVENT_FLAGS   = 8'h24;
    localparam logic [7:0]  OFS_EVENT_CLEAR   = 8'h28;
    localparam logic [7:0]  OFS_EVENT_ENABLE  = 8'h2c;
    localparam logic [7:0]  OFS_POINTERS      = 8'h30;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int POS_CRC_TYPE        = 15;
    localparam int POS_PLEN_LSB        = 8;
    localparam int POS_CHAN_ENABLE     = 7;
    localparam int POS_DEST_HALF_FULL  = 4;
    localparam int POS_BLOCK_COMPLETE  = 3;
    localparam int POS_CELL_COMPLETE   = 2;
    localparam int POS_TRANSFER_ABORT  = 1;
    localparam int POS_ADDRESS_ERROR   = 0;
    localparam int NUM_FLAGS           = 5;

    // ****************************************************************
    // reset values and limits
    // ****************************************************************
    localparam logic [31:0] RST_XOR_TAP     = 32'h0000_0000;
    localparam logic [31:0] RST_WORD        = 32'h0000_0000;
    localparam logic [4:0]  RST_PLEN        = 5'h1f;
    localparam logic [15:0] RST_SIZE        = 16'h0001;
    localparam logic [7:0]  RST_ABORT_IRQ   = 8'hff;
    localparam logic [15:0] ONE_BYTE        = 16'h0001;

    typedef enum logic [0:0] {
        DCXF_LFSR,
        DCXF_IP_HEADER
    } dcxf_crc_type_t;

endpackage : dcxf_pkg

// ### core/dcxf_crc_engine.sv
`timescale 1ns/1ps

module dcxf_crc_engine (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        crc_type_select,
    input  wire logic [4:0]  plen,
    input  wire logic [31:0] crc_xor_tap_enable,
    input  wire logic        seed_wr,
    input  wire logic [31:0] seed_data,
    input  wire logic        byte_valid,
    input  wire logic [7:0]  byte_data,
    output logic      [31:0] crc_value_seed
);

    // ****************************************************************
    // shift state
    // ****************************************************************
    logic [31:0] crc_ff;
    logic [31:0] nxt_crc;
    logic [31:0] lfsr_step [0:8];
    logic [16:0] ip_sum;
    logic [15:0] ip_fold;
    logic [31:0] len_mask;

    assign lfsr_step[0] = crc_ff;

    // one serial shift per data bit; tap bits gate the feedback xor
    genvar gb;
    genvar gs;
    generate
        for (gb = 0; gb < 8; gb++)
        begin : g_bit
            logic fb;
            assign fb = lfsr_step[gb][plen] ^ byte_data[gb];
            for (gs = 0; gs < 32; gs++)
            begin : g_stage
                if (gs == 0)
                begin : g_first
                    assign lfsr_step[gb+1][gs] = fb & crc_xor_tap_enable[gs]; // RULE1
                end
                else
                begin : g_rest
                    // cleared tap: plain copy of preceding stage
                    assign lfsr_step[gb+1][gs] = lfsr_step[gb][gs-1]
                        ^ (fb & crc_xor_tap_enable[gs]); // RULE1 RULE2
                end
            end
        end
    endgenerate

    // ones complement byte sum, tap register not consulted
    assign ip_sum  = {1'b0, crc_ff[15:0]} + {9'h000, byte_data}; // RULE3
    assign ip_fold = ip_sum[15:0] + {15'h0000, ip_sum[16]};

    always_comb
    begin
        nxt_crc = crc_ff;
        if (seed_wr)
        begin
            nxt_crc = seed_data; // RULE9
        end
        else if (byte_valid)
        begin
            if (crc_type_select)
            begin
                nxt_crc = {16'h0000, ip_fold}; // RULE3
            end
            else
            begin
                nxt_crc = lfsr_step[8];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            crc_ff <= dcxf_pkg::RST_WORD;
        end
        else
        begin
            crc_ff <= nxt_crc;
        end
    end

    // bits above the polynomial length and upper half in ip mode read zero
    assign len_mask = 32'hffff_ffff >> (5'd31 - plen);
    assign crc_value_seed = crc_type_select ? {16'h0000, crc_ff[15:0]} // RULE10
                                            : (crc_ff & len_mask);

endmodule : dcxf_crc_engine

// ### core/dcxf_dma_channel.sv
`timescale 1ns/1ps

// Behaviour
// RULE1: in lfsr mode a set tap bit xors feedback into that stage
// RULE2: in lfsr mode a clear tap bit copies the preceding stage only
// RULE3: in ip header mode the tap register is ignored
// RULE4: set half-full flag when destination pointer equals half destination size
// RULE5: set block flag after larger of sizes moved, or on pattern match
// RULE6: set cell flag each time cell size bytes have moved
// RULE7: matching abort irq aborts the channel and sets abort flag
// RULE8: set address error flag on invalid source or destination address
// RULE9: writing crc data seeds generator, reading returns current crc
// RULE10: ip header mode keeps checksum in low 16 bits, upper read zero
// RULE11: event flags stay set until software clears them
// RULE12: all tap enable bits reset to zero
module dcxf_dma_channel (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        src_rd_valid,
    input  wire logic [7:0]  src_rd_data,
    input  wire logic        src_addr_invalid,
    input  wire logic        dst_addr_invalid,
    input  wire logic        pattern_match,
    input  wire logic        irq_valid,
    input  wire logic [7:0]  irq_number,
    output logic             chan_busy,
    output logic             dst_wr_valid,
    output logic      [7:0]  dst_wr_data,
    output logic             irq
);

    // ****************************************************************
    // bus decode
    // ****************************************************************
    logic        wr_en;
    logic        rd_en;
    logic        mapped;
    logic [31:0] crc_control_ff;
    logic [31:0] crc_xor_tap_enable_ff;
    logic [15:0] source_size_ff;
    logic [15:0] dest_size_ff;
    logic [15:0] cell_size_ff;
    logic [7:0]  abort_request_number_ff;
    logic [4:0]  flags_ff;
    logic [4:0]  enable_ff;
    logic [4:0]  nxt_flags;
    logic [4:0]  set_ev;
    logic [4:0]  clr_ev;
    logic        chan_on_ff;
    logic [15:0] src_pointer_ff;
    logic [15:0] dest_pointer_ff;
    logic [15:0] cell_count_ff;
    logic [15:0] block_len;
    logic        byte_move;
    logic        last_byte;
    logic        cell_done;
    logic        abort_hit;
    logic        addr_err;
    logic        start_req;
    logic        stop_req;
    logic [31:0] crc_value_seed;
    logic [31:0] rdata;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & ~pwrite;
    assign pready  = 1'b1;
    assign mapped  = (paddr <= dcxf_pkg::OFS_POINTERS) && (paddr[1:0] == 2'b00);
    assign pslverr = psel & penable & ~mapped;

    // ****************************************************************
    // control registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            crc_control_ff          <= {dcxf_pkg::RST_WORD[31:13], dcxf_pkg::RST_PLEN,
                                        dcxf_pkg::RST_WORD[7:0]};
            crc_xor_tap_enable_ff   <= dcxf_pkg::RST_XOR_TAP; // RULE12
            source_size_ff          <= dcxf_pkg::RST_SIZE;
            dest_size_ff            <= dcxf_pkg::RST_SIZE;
            cell_size_ff            <= dcxf_pkg::RST_SIZE;
            abort_request_number_ff <= dcxf_pkg::RST_ABORT_IRQ;
            enable_ff               <= dcxf_pkg::RST_WORD[4:0];
        end
        else if (wr_en)
        begin
            if (hit(paddr, dcxf_pkg::OFS_CRC_CONTROL))
                crc_control_ff <= pwdata;
            if (hit(paddr, dcxf_pkg::OFS_CRC_XOR_TAP))
                crc_xor_tap_enable_ff <= pwdata;
            if (hit(paddr, dcxf_pkg::OFS_SOURCE_SIZE))
                source_size_ff <= pwdata[15:0];
            if (hit(paddr, dcxf_pkg::OFS_DEST_SIZE))
                dest_size_ff <= pwdata[15:0];
            if (hit(paddr, dcxf_pkg::OFS_CELL_SIZE))
                cell_size_ff <= pwdata[15:0];
            if (hit(paddr, dcxf_pkg::OFS_ABORT_IRQ))
                abort_request_number_ff <= pwdata[7:0];
            if (hit(paddr, dcxf_pkg::OFS_EVENT_ENABLE))
                enable_ff <= pwdata[4:0];
        end
    end

    assign start_req = wr_en && hit(paddr, dcxf_pkg::OFS_CHAN_CONTROL)
                       && pwdata[dcxf_pkg::POS_CHAN_ENABLE];
    assign stop_req  = wr_en && hit(paddr, dcxf_pkg::OFS_CHAN_CONTROL)
                       && !pwdata[dcxf_pkg::POS_CHAN_ENABLE];

    // ****************************************************************
    // channel transfer
    // ****************************************************************
    assign block_len = (source_size_ff > dest_size_ff) ? source_size_ff : dest_size_ff;
    assign abort_hit = chan_on_ff && irq_valid
                       && (irq_number == abort_request_number_ff); // RULE7
    assign addr_err  = chan_on_ff && (src_addr_invalid || dst_addr_invalid); // RULE8
    assign byte_move = chan_on_ff && src_rd_valid && !abort_hit && !addr_err;
    assign last_byte = byte_move && (src_pointer_ff + dcxf_pkg::ONE_BYTE >= block_len);
    assign cell_done = byte_move && (cell_count_ff + dcxf_pkg::ONE_BYTE >= cell_size_ff);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            chan_on_ff      <= 1'b0;
            src_pointer_ff  <= dcxf_pkg::RST_WORD[15:0];
            dest_pointer_ff <= dcxf_pkg::RST_WORD[15:0];
            cell_count_ff   <= dcxf_pkg::RST_WORD[15:0];
        end
        else if (start_req && !chan_on_ff)
        begin
            chan_on_ff      <= 1'b1;
            src_pointer_ff  <= dcxf_pkg::RST_WORD[15:0];
            dest_pointer_ff <= dcxf_pkg::RST_WORD[15:0];
            cell_count_ff   <= dcxf_pkg::RST_WORD[15:0];
        end
        else if (stop_req || abort_hit || addr_err || last_byte
                 || (chan_on_ff && pattern_match))
        begin
            chan_on_ff <= 1'b0; // RULE7
            if (byte_move)
            begin
                src_pointer_ff  <= src_pointer_ff + dcxf_pkg::ONE_BYTE;
                dest_pointer_ff <= dest_pointer_ff + dcxf_pkg::ONE_BYTE;
            end
        end
        else if (byte_move)
        begin
            src_pointer_ff  <= src_pointer_ff + dcxf_pkg::ONE_BYTE;
            // destination wraps at its own size
            if (dest_pointer_ff + dcxf_pkg::ONE_BYTE >= dest_size_ff)
                dest_pointer_ff <= dcxf_pkg::RST_WORD[15:0];
            else
                dest_pointer_ff <= dest_pointer_ff + dcxf_pkg::ONE_BYTE;
            cell_count_ff <= cell_done ? dcxf_pkg::RST_WORD[15:0]
                                       : cell_count_ff + dcxf_pkg::ONE_BYTE;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dst_wr_valid <= 1'b0;
            dst_wr_data  <= dcxf_pkg::RST_WORD[7:0];
        end
        else
        begin
            dst_wr_valid <= byte_move;
            if (byte_move)
                dst_wr_data <= src_rd_data;
        end
    end

    assign chan_busy = chan_on_ff;

    // ****************************************************************
    // crc generator
    // ****************************************************************
    dcxf_crc_engine u_crc (
        .pclk               (pclk),
        .presetn            (presetn),
        .crc_type_select    (crc_control_ff[dcxf_pkg::POS_CRC_TYPE]),
        .plen               (crc_control_ff[dcxf_pkg::POS_PLEN_LSB +: 5]),
        .crc_xor_tap_enable (crc_xor_tap_enable_ff),
        .seed_wr            (wr_en && hit(paddr, dcxf_pkg::OFS_CRC_SEED)), // RULE9
        .seed_data          (pwdata),
        .byte_valid         (byte_move || (wr_en && hit(paddr, dcxf_pkg::OFS_CRC_DATA_IN))),
        .byte_data          (byte_move ? src_rd_data : pwdata[7:0]),
        .crc_value_seed     (crc_value_seed)
    );

    // ****************************************************************
    // event flags and interrupt
    // ****************************************************************
    always_comb
    begin
        set_ev = '0;
        set_ev[dcxf_pkg::POS_DEST_HALF_FULL] = byte_move
            && (dest_pointer_ff + dcxf_pkg::ONE_BYTE == (dest_size_ff >> 1)); // RULE4
        set_ev[dcxf_pkg::POS_BLOCK_COMPLETE] = last_byte
            || (chan_on_ff && pattern_match); // RULE5
        set_ev[dcxf_pkg::POS_CELL_COMPLETE]  = cell_done; // RULE6
        set_ev[dcxf_pkg::POS_TRANSFER_ABORT] = abort_hit; // RULE7
        set_ev[dcxf_pkg::POS_ADDRESS_ERROR]  = addr_err; // RULE8
    end

    assign clr_ev    = (wr_en && hit(paddr, dcxf_pkg::OFS_EVENT_CLEAR)) ? pwdata[4:0] : 5'h00;
    assign nxt_flags = (flags_ff & ~clr_ev) | set_ev; // RULE11

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags_ff <= dcxf_pkg::RST_WORD[4:0];
        else
            flags_ff <= nxt_flags; // RULE11
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(nxt_flags & enable_ff);
    end

    // ****************************************************************
    // read mux
    // ****************************************************************
    always_comb
    begin
        rdata = '0;
        case (paddr)
            dcxf_pkg::OFS_CRC_CONTROL:  rdata = crc_control_ff;
            dcxf_pkg::OFS_CRC_SEED:     rdata = crc_value_seed; // RULE9
            dcxf_pkg::OFS_CRC_XOR_TAP:  rdata = crc_xor_tap_enable_ff;
            dcxf_pkg::OFS_CHAN_CONTROL: rdata = {24'h000000, chan_on_ff, 7'h00};
            dcxf_pkg::OFS_SOURCE_SIZE:  rdata = {16'h0000, source_size_ff};
            dcxf_pkg::OFS_DEST_SIZE:    rdata = {16'h0000, dest_size_ff};
            dcxf_pkg::OFS_CELL_SIZE:    rdata = {16'h0000, cell_size_ff};
            dcxf_pkg::OFS_ABORT_IRQ:    rdata = {24'h000000, abort_request_number_ff};
            dcxf_pkg::OFS_EVENT_FLAGS:  rdata = {27'h0000000, flags_ff};
            dcxf_pkg::OFS_EVENT_ENABLE: rdata = {27'h0000000, enable_ff};
            dcxf_pkg::OFS_POINTERS:     rdata = {dest_pointer_ff, src_pointer_ff};
            default:                    rdata = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= dcxf_pkg::RST_WORD;
        else if (rd_en && !penable)
            prdata <= rdata;
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_byte_taken;
        byte_move;
    endsequence

    sequence s_abort_clear;
        clr_ev[1] && !abort_hit;
    endsequence

    sequence s_match_on;
        chan_on_ff && pattern_match;
    endsequence

    sequence s_seed_write;
        wr_en && paddr == dcxf_pkg::OFS_CRC_SEED && !crc_control_ff[15]
        && crc_control_ff[12:8] == 5'h1f;
    endsequence

    a_tap_reset_zero: assert property (@(posedge pclk)
        $rose(presetn) |-> crc_xor_tap_enable_ff == 32'h0) // RULE12
        else $error("tap register not zero after reset");

    a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        flags_ff[0] && !clr_ev[0] |=> flags_ff[0]) // RULE11
        else $error("address error flag dropped without clear");

    a_abort_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        abort_hit |=> flags_ff[dcxf_pkg::POS_TRANSFER_ABORT] && !chan_on_ff) // RULE7
        else $error("abort did not stop channel");

    a_addr_err_set: assert property (@(posedge pclk) disable iff (!presetn)
        chan_on_ff && src_addr_invalid |=> flags_ff[dcxf_pkg::POS_ADDRESS_ERROR]) // RULE8
        else $error("address error flag not set");

    a_cell_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        cell_done |=> flags_ff[dcxf_pkg::POS_CELL_COMPLETE]) // RULE6
        else $error("cell flag not set");

    a_block_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        s_match_on |=> flags_ff[3] && !chan_on_ff) // RULE5
        else $error("block flag not set on match");

    a_half_full_set: assert property (@(posedge pclk) disable iff (!presetn)
        byte_move && (dest_pointer_ff + 16'h1 == (dest_size_ff >> 1)) |=> flags_ff[4]) // RULE4
        else $error("half full flag not set");

    a_ip_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
        crc_control_ff[dcxf_pkg::POS_CRC_TYPE] |-> crc_value_seed[31:16] == 16'h0) // RULE10
        else $error("upper crc half not zero in ip mode");

    a_seed_loads: assert property (@(posedge pclk) disable iff (!presetn)
        s_seed_write |=> crc_value_seed == $past(pwdata)) // RULE9
        else $error("crc seed not loaded");

    a_byte_forward: assert property (@(posedge pclk) disable iff (!presetn)
        s_byte_taken |=> dst_wr_valid && dst_wr_data == $past(src_rd_data))
        else $error("byte not forwarded");

    a_flag_clears: assert property (@(posedge pclk) disable iff (!presetn)
        s_abort_clear |=> !flags_ff[1]) // RULE11
        else $error("abort flag not cleared");

    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        $stable(enable_ff) |-> irq == |(flags_ff & enable_ff))
        else $error("irq level wrong");

    a_unmapped_err: assert property (@(posedge pclk)
        psel && penable && paddr > dcxf_pkg::OFS_POINTERS |-> pslverr)
        else $error("unmapped access not refused");

endmodule : dcxf_dma_channel

// ### verif/dcxf_mem_model.sv
`timescale 1ns/1ps

// ****************
// source memory stand-in: offers bytes, stalls at random
// ****************
module dcxf_mem_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       go,
    input  wire logic       stall,
    input  wire logic [7:0] count,
    output logic            src_rd_valid,
    output logic      [7:0] src_rd_data
);
    logic [7:0] sent_ff;

    // idle data flips every cycle so a stale byte never looks fresh
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sent_ff      <= 8'h00;
            src_rd_valid <= 1'b0;
            src_rd_data  <= 8'h00;
        end
        else if (go && !stall && sent_ff < count)
        begin
            src_rd_valid <= 1'b1;
            src_rd_data  <= 8'h30 + sent_ff;
            sent_ff      <= sent_ff + 8'h01;
        end
        else
        begin
            src_rd_valid <= 1'b0;
            src_rd_data  <= ~src_rd_data;
            if (!go)
                sent_ff <= 8'h00;
        end
    end
endmodule : dcxf_mem_model

// ### verif/dma_crc_xor_and_channel_flags_tb.sv
`timescale 1ns/1ps

module dma_crc_xor_and_channel_flags_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, chan_busy, dst_wr_valid, irq, src_rd_valid, serr;
    logic [7:0]  src_rd_data, dst_wr_data;
    logic        src_addr_invalid = 1'b0;
    logic        dst_addr_invalid = 1'b0;
    logic        pattern_match = 1'b0;
    logic        irq_valid = 1'b0;
    logic [7:0]  irq_number = 8'h00;
    logic        go = 1'b0;
    logic        stall = 1'b0;
    logic [7:0]  count = 8'h00;
    logic [31:0] rng = 32'he184;
    logic [31:0] rdat, crc_m, tap, ipv[2], fexp;
    logic [7:0]  exp8, q[$];
    int          mismatches = 0;
    int          n_checks = 0;
    int          cyc = 0;
    int          ssz[2] = '{6, 10};
    int          dsz[2] = '{8, 4};
    int          csz[2] = '{3, 5};
    int          nb[2] = '{8, 9};
    logic [31:0] evx[5] = '{32'h1, 32'h1, 32'h0, 32'h2, 32'h8};

    dcxf_dma_channel dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_rd_valid(src_rd_valid), .src_rd_data(src_rd_data),
        .src_addr_invalid(src_addr_invalid), .dst_addr_invalid(dst_addr_invalid),
        .pattern_match(pattern_match), .irq_valid(irq_valid), .irq_number(irq_number),
        .chan_busy(chan_busy), .dst_wr_valid(dst_wr_valid), .dst_wr_data(dst_wr_data),
        .irq(irq));
    dcxf_mem_model mem_u (.pclk(pclk), .presetn(presetn), .go(go), .stall(stall),
        .count(count), .src_rd_valid(src_rd_valid), .src_rd_data(src_rd_data));

    always #10 pclk = ~pclk;

    // ****************
    // helpers
    // ****************
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    // serial lfsr, lsb of each byte first, feedback from the top stage
    function automatic logic [31:0] lfsr(input logic [31:0] c, input logic [31:0] t,
                                         input logic [7:0] b);
        logic fb;
        for (int i = 0; i < 8; i++)
        begin
            fb = c[31] ^ b[i];
            c = {c[30:0], 1'b0} ^ (fb ? t : 32'h0);
        end
        return c;
    endfunction : lfsr

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask : rd

    always @(posedge pclk)
    begin
        rng <= xs(rng);
        stall <= rng[0] & rng[5];
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            report_and_stop();
        end
        if (dst_wr_valid === 1'b1)
        begin
            exp8 = (q.size() > 0) ? q.pop_front() : ~dst_wr_data;
            chk({24'h0, dst_wr_data}, {24'h0, exp8});
        end
    end

    // ****************
    // main sequence
    // ****************
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(dcxf_pkg::OFS_CRC_XOR_TAP, dcxf_pkg::RST_XOR_TAP);
        rd(dcxf_pkg::OFS_CRC_CONTROL, 32'h0000_1f00);
        rd(dcxf_pkg::OFS_ABORT_IRQ, 32'h0000_00ff);
        rd(dcxf_pkg::OFS_EVENT_FLAGS, 32'h0);
        apb(1'b0, 8'h34, 32'h0);
        chk({31'h0, serr}, 32'h1);
        chk(rdat, 32'h0);
        for (int j = 0; j < 2; j++)
        begin
            tap = (j == 0) ? 32'h0 : rng;
            crc_m = xs(rng);
            wr(dcxf_pkg::OFS_CRC_XOR_TAP, tap);
            rd(dcxf_pkg::OFS_CRC_XOR_TAP, tap);
            wr(dcxf_pkg::OFS_CRC_SEED, crc_m);
            rd(dcxf_pkg::OFS_CRC_SEED, crc_m);
            for (int i = 0; i < 4; i++)
            begin
                exp8 = rng[7:0] ^ 8'(i);
                crc_m = lfsr(crc_m, tap, exp8);
                wr(dcxf_pkg::OFS_CRC_DATA_IN, {24'h0, exp8});
            end
            rd(dcxf_pkg::OFS_CRC_SEED, crc_m);
        end
        wr(dcxf_pkg::OFS_CRC_CONTROL, 32'h0000_9f00);
        for (int j = 0; j < 2; j++)
        begin
            wr(dcxf_pkg::OFS_CRC_XOR_TAP, (j == 0) ? 32'h0 : rng | 32'h1);
            wr(dcxf_pkg::OFS_CRC_SEED, 32'h0);
            wr(dcxf_pkg::OFS_CRC_DATA_IN, 32'hf1);
            wr(dcxf_pkg::OFS_CRC_DATA_IN, 32'h9c);
            apb(1'b0, dcxf_pkg::OFS_CRC_SEED, 32'h0);
            ipv[j] = rdat;
        end
        chk(ipv[1], ipv[0]);
        chk(ipv[0], 32'h0000_018d);
        chk(ipv[0] & 32'hffff_0000, 32'h0);
        wr(dcxf_pkg::OFS_CRC_SEED, 32'habcd_1234);
        apb(1'b0, dcxf_pkg::OFS_CRC_SEED, 32'h0);
        chk(rdat, 32'h0000_1234);
        for (int r = 0; r < 2; r++)
        begin
            wr(dcxf_pkg::OFS_SOURCE_SIZE, ssz[r]);
            wr(dcxf_pkg::OFS_DEST_SIZE, dsz[r]);
            wr(dcxf_pkg::OFS_CELL_SIZE, csz[r]);
            for (int i = 0; i < nb[r]; i++)
                q.push_back(8'h30 + 8'(i));
            wr(dcxf_pkg::OFS_CHAN_CONTROL, 32'h80);
            count <= 8'(nb[r]);
            go <= 1'b1;
            while (q.size() > 0)
                @(posedge pclk);
            repeat (3) @(posedge pclk);
            go <= 1'b0;
            chk(32'(q.size()), 32'h0);
            fexp = {27'h0, nb[r] >= dsz[r] / 2, nb[r] >= (ssz[r] > dsz[r] ? ssz[r] : dsz[r]),
                    nb[r] >= csz[r], 2'b00};
            rd(dcxf_pkg::OFS_EVENT_FLAGS, fexp);
            if (r == 0)
            begin
                wr(dcxf_pkg::OFS_EVENT_ENABLE, 32'h0);
                repeat (3) @(posedge pclk);
                chk({31'h0, irq}, 32'h0);
                wr(dcxf_pkg::OFS_EVENT_ENABLE, 32'h4);
                repeat (3) @(posedge pclk);
                chk({31'h0, irq}, 32'h1);
                rd(dcxf_pkg::OFS_EVENT_FLAGS, fexp);
                wr(dcxf_pkg::OFS_EVENT_CLEAR, 32'h4);
                repeat (3) @(posedge pclk);
                chk({31'h0, irq}, 32'h0);
                rd(dcxf_pkg::OFS_EVENT_FLAGS, fexp & ~32'h4);
                wr(dcxf_pkg::OFS_EVENT_ENABLE, 32'h0);
            end
            wr(dcxf_pkg::OFS_CHAN_CONTROL, 32'h0);
            wr(dcxf_pkg::OFS_EVENT_CLEAR, 32'h1f);
        end
        wr(dcxf_pkg::OFS_ABORT_IRQ, 32'h2a);
        for (int e = 0; e < 5; e++)
        begin
            wr(dcxf_pkg::OFS_EVENT_CLEAR, 32'h1f);
            wr(dcxf_pkg::OFS_CHAN_CONTROL, 32'h80);
            src_addr_invalid <= (e == 0);
            dst_addr_invalid <= (e == 1);
            irq_valid <= (e == 2 || e == 3);
            irq_number <= (e == 3) ? 8'h2a : 8'h29;
            pattern_match <= (e == 4);
            @(posedge pclk);
            src_addr_invalid <= 1'b0;
            dst_addr_invalid <= 1'b0;
            irq_valid <= 1'b0;
            pattern_match <= 1'b0;
            @(posedge pclk);
            rd(dcxf_pkg::OFS_EVENT_FLAGS, evx[e]);
            if (e == 2 || e == 3)
                chk({31'h0, chan_busy}, {31'h0, e == 2});
            wr(dcxf_pkg::OFS_CHAN_CONTROL, 32'h0);
        end
        report_and_stop();
    end
endmodule : dma_crc_xor_and_channel_flags_tb
